// *** mmp_port.sv ***
// Purpose: memory message port, device end
// Assumes: binding table and surface state loaded through the config ports
// Notes:   both caches share one backing array; render cache is write-through
//          a write without commit is never answered; ordering is the thread's job
`timescale 1ns/10ps
`default_nettype none
module mmp_port (
    input  wire logic                         clock_in,
    input  wire logic                         rst_in,
    mmp_if.port_end                           link,
    input  wire logic [mmp_pkg::ADDR_W-1:0]   gen_state_base_in,
    input  wire logic [mmp_pkg::ADDR_W-1:0]   gen_state_bound_in,
    input  wire logic                         bt_wr_in,
    input  wire logic [3:0]                   bt_idx_in,
    input  wire logic [mmp_pkg::ADDR_W-1:0]   bt_base_in,
    input  wire logic [mmp_pkg::ADDR_W-1:0]   bt_size_in,
    input  wire logic                         bt_is_buffer_in,
    output logic                              busy_out,
    output logic [1:0]                        last_cache_out
);
    localparam int MSG_W = $bits(mmp_pkg::mmp_msg_s);

    typedef enum logic [1:0] {MMP_IDLE, MMP_ACC0, MMP_ACC1, MMP_RESP} mmp_state_e;

    mmp_state_e        state_reg;
    mmp_pkg::mmp_msg_s cur_reg;
    mmp_pkg::mmp_rsp_s rsp_reg;
    logic              rsp_valid_reg;
    logic              busy_reg;
    logic [1:0]        last_cache_reg;
    logic [mmp_pkg::DATA_W-1:0] mem_reg [mmp_pkg::MEM_DEPTH];
    logic [mmp_pkg::ADDR_W-1:0] bt_base_reg [mmp_pkg::BT_DEPTH];
    logic [mmp_pkg::ADDR_W-1:0] bt_size_reg [mmp_pkg::BT_DEPTH];
    logic                       bt_buf_reg  [mmp_pkg::BT_DEPTH];

    logic              q_valid;
    logic              q_ready;
    logic [MSG_W-1:0]  q_data;

    mmp_state_e        state_next;
    mmp_pkg::mmp_rsp_s rsp_next;
    logic              rsp_valid_next;
    logic              busy_next;
    logic [1:0]        last_cache_next;

    mmp_skid_buf #(.WIDTH(MSG_W)) u_buf (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .in_valid_in   (link.msg_valid),
        .in_ready_out  (link.msg_ready),
        .in_data_in    (link.msg),
        .out_valid_out (q_valid),
        .out_ready_in  (q_ready),
        .out_data_out  (q_data)
    );

    assign q_ready = (state_reg == MMP_IDLE);
    wire   pull    = q_valid & q_ready;

    // surface resolution
    wire       stateless  = (cur_reg.bti == mmp_pkg::STATELESS_BTI);
    wire [3:0] bt_slot    = cur_reg.bti[3:0];
    // stateless: buffer type, four-channel float, stride 0, pitch 16, no tiling or fence
    wire [mmp_pkg::ADDR_W-1:0] surf_base = stateless
        ? gen_state_base_in + mmp_pkg::STATELESS_PITCH * 32'h0 + cur_reg.offset1
        : bt_base_reg[bt_slot];
    wire [mmp_pkg::ADDR_W-1:0] surf_bound = stateless
        ? gen_state_bound_in
        : bt_base_reg[bt_slot] + bt_size_reg[bt_slot];
    wire       surf_buffer = stateless ? 1'b1 : bt_buf_reg[bt_slot];

    wire is_write   = (cur_reg.sfid == mmp_pkg::MMP_SFID_WRITE);
    wire is_media   = (cur_reg.op == mmp_pkg::MMP_OP_MEDIA_BLOCK);
    wire is_dual    = (cur_reg.op == mmp_pkg::MMP_OP_DUAL_BLOCK);
    // data cache is read-only: a write message never reaches it
    wire use_data_c = ~is_write & (cur_reg.cache_sel == mmp_pkg::MMP_CACHE_DATA);
    // media block has no linear address; stateless or buffer surfaces are refused
    wire illegal    = is_media ? stateless | surf_buffer
                               : ~surf_buffer;
    wire [mmp_pkg::ADDR_W-1:0] media_off = {cur_reg.y, cur_reg.x};
    wire [mmp_pkg::ADDR_W-1:0] off_sel   = (state_reg == MMP_ACC1) ? cur_reg.offset1 : cur_reg.offset0;
    wire [mmp_pkg::ADDR_W-1:0] acc_addr  = surf_base + (is_media ? media_off : off_sel);
    wire        out_of_range = (acc_addr >= surf_bound);
    wire [mmp_pkg::MEM_IDX_W-1:0] idx = acc_addr[mmp_pkg::MEM_IDX_W+1:2];
    // vertex write keeps only channels the format carries; data never converted
    wire [mmp_pkg::DATA_W-1:0] wmask = (cur_reg.op == mmp_pkg::MMP_OP_VERTEX_WR)
        ? {{8{cur_reg.fmt_channels[3]}}, {8{cur_reg.fmt_channels[2]}},
           {8{cur_reg.fmt_channels[1]}}, {8{cur_reg.fmt_channels[0]}}}
        : {mmp_pkg::DATA_W{1'b1}};
    wire [mmp_pkg::DATA_W-1:0] wval = (mem_reg[idx] & ~wmask) | (cur_reg.wdata & wmask);
    // equal dual-block offsets collapse into one access
    wire second_acc = is_dual & (cur_reg.offset0 != cur_reg.offset1);
    wire do_access  = ((state_reg == MMP_ACC0) | (state_reg == MMP_ACC1)) & ~illegal & ~out_of_range;
    wire acc_ok     = ~illegal & ~out_of_range;
    wire answers    = ~is_write | cur_reg.commit;
    wire rsp_done   = rsp_valid_reg & link.rsp_ready;

    // one write port per table slot; neither the table nor the array is reset, load the table first
    for (genvar s = 0; s < mmp_pkg::BT_DEPTH; s++) begin : g_bt_slot
        wire slot_wr = bt_wr_in & (bt_idx_in == 4'(s));
        always_ff @(posedge clock_in) begin
            if (slot_wr) begin
                bt_base_reg[s] <= bt_base_in;
                bt_size_reg[s] <= bt_size_in;
                bt_buf_reg[s]  <= bt_is_buffer_in;
            end
        end
    end

    // write-through array: a later read sees the write at once
    always_ff @(posedge clock_in) begin
        if (do_access & is_write) mem_reg[idx] <= wval;
    end

    // next state and answer; the registers below only latch them
    always_comb begin
        state_next      = state_reg;
        rsp_next        = rsp_reg;
        rsp_valid_next  = rsp_valid_reg;
        busy_next       = busy_reg;
        last_cache_next = last_cache_reg;
        unique case (state_reg)
            MMP_IDLE: begin
                if (pull) begin
                    rsp_next   = '0;
                    busy_next  = 1'b1;
                    state_next = MMP_ACC0;
                end
            end
            MMP_ACC0, MMP_ACC1: begin
                // a refused or out-of-range access touches nothing and ends the message
                last_cache_next = {1'b1, use_data_c};
                if (illegal)
                    rsp_next.status = mmp_pkg::MMP_ST_ILLEGAL;
                else if (out_of_range)
                    rsp_next.status = mmp_pkg::MMP_ST_BOUND_ERR;
                else if (!is_write && state_reg == MMP_ACC0)
                    rsp_next.rdata0 = mem_reg[idx];
                else if (!is_write)
                    rsp_next.rdata1 = mem_reg[idx];
                if (state_reg == MMP_ACC0 && second_acc && acc_ok)
                    state_next = MMP_ACC1;
                else
                    state_next = MMP_RESP;
            end
            MMP_RESP: begin
                // a plain write frees the port at once, so a burst of them drains quickly
                if (answers) begin
                    if (!is_write && !second_acc && is_dual)
                        rsp_next.rdata1 = rsp_reg.rdata0;
                    rsp_next.is_commit = is_write;
                    rsp_valid_next     = 1'b1;
                end else begin
                    busy_next  = 1'b0;
                    state_next = MMP_IDLE;
                end
                if (rsp_done) begin
                    rsp_valid_next = 1'b0;
                    busy_next      = 1'b0;
                    state_next     = MMP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg      <= MMP_IDLE;
            cur_reg        <= '0;
            rsp_reg        <= '0;
            rsp_valid_reg  <= 1'b0;
            busy_reg       <= 1'b0;
            last_cache_reg <= 2'h0;
        end else begin
            if (pull) cur_reg <= mmp_pkg::mmp_msg_s'(q_data);
            state_reg      <= state_next;
            rsp_reg        <= rsp_next;
            rsp_valid_reg  <= rsp_valid_next;
            busy_reg       <= busy_next;
            last_cache_reg <= last_cache_next;
        end
    end

    assign link.rsp_valid = rsp_valid_reg;
    assign link.rsp       = rsp_reg;
    assign busy_out       = busy_reg;
    assign last_cache_out = last_cache_reg;
endmodule : mmp_port
`default_nettype wire

// *** mmp_pkg.sv ***
// Purpose: shared constants and types for the memory message port
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   message and response layouts used by both ends
package mmp_pkg;
    localparam int          ADDR_W          = 32;
    localparam int          DATA_W          = 32;
    localparam int          BTI_W           = 8;
    localparam logic [7:0]  STATELESS_BTI   = 8'hff;
    localparam logic [31:0] STATELESS_PITCH = 32'h0000_0010;
    localparam logic [31:0] STATELESS_VSTR  = 32'h0000_0000;
    localparam int          BT_DEPTH        = 16;
    localparam int          MEM_DEPTH       = 256;
    localparam int          MEM_IDX_W       = 8;
    localparam int          BUF_DEPTH       = 2;
    localparam logic [3:0]  CH_ALL          = 4'hf;

    typedef enum logic [2:0] {
        MMP_OP_BLOCK,
        MMP_OP_DUAL_BLOCK,
        MMP_OP_SCATTER,
        MMP_OP_VERTEX_WR,
        MMP_OP_MEDIA_BLOCK
    } mmp_op_e;

    typedef enum logic {
        MMP_SFID_READ,
        MMP_SFID_WRITE
    } mmp_sfid_e;

    typedef enum logic {
        MMP_CACHE_RENDER,
        MMP_CACHE_DATA
    } mmp_cache_e;

    typedef enum logic [1:0] {
        MMP_ST_OK,
        MMP_ST_BOUND_ERR,
        MMP_ST_ILLEGAL
    } mmp_status_e;

    typedef struct packed {
        mmp_sfid_e             sfid;
        mmp_op_e               op;
        mmp_cache_e            cache_sel;
        logic                  commit;
        logic [BTI_W-1:0]      bti;
        logic [ADDR_W-1:0]     offset0;
        logic [ADDR_W-1:0]     offset1;
        logic [15:0]           x;
        logic [15:0]           y;
        logic [3:0]            fmt_channels;
        logic [DATA_W-1:0]     wdata;
    } mmp_msg_s;

    typedef struct packed {
        logic [DATA_W-1:0]     rdata0;
        logic [DATA_W-1:0]     rdata1;
        logic                  is_commit;
        mmp_status_e           status;
    } mmp_rsp_s;
endpackage : mmp_pkg

// *** mmp_if.sv ***
// Purpose: message link between execution-unit thread and memory port
// Assumes: both ends on clock_in
// Notes:   valid/ready handshake in both directions
`timescale 1ns/10ps
`default_nettype none
interface mmp_if (
    input wire logic clock_in
);
    logic             msg_valid;
    logic             msg_ready;
    mmp_pkg::mmp_msg_s msg;
    logic             rsp_valid;
    logic             rsp_ready;
    mmp_pkg::mmp_rsp_s rsp;

    modport port_end (
        input  msg_valid,
        output msg_ready,
        input  msg,
        output rsp_valid,
        input  rsp_ready,
        output rsp
    );
    modport thread_end (
        output msg_valid,
        input  msg_ready,
        output msg,
        input  rsp_valid,
        output rsp_ready,
        input  rsp
    );
endinterface : mmp_if
`default_nettype wire

// *** mmp_skid_buf.sv ***
// Purpose: two-entry valid/ready buffer on the message path
// Assumes: synchronous reset
// Notes:   in_ready_out decodes only the registered count, so a stalled drain loses no word
`timescale 1ns/10ps
`default_nettype none
module mmp_skid_buf #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    logic [WIDTH-1:0] mem_reg [mmp_pkg::BUF_DEPTH];
    logic             rd_ptr_reg;
    logic             wr_ptr_reg;
    logic [1:0]       count_reg;
    wire              push = in_valid_in & in_ready_out;
    wire              pop  = out_valid_out & out_ready_in;

    assign in_ready_out  = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign out_data_out  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop)  rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clock_in) begin
        if (push) mem_reg[wr_ptr_reg] <= in_data_in;
    end
endmodule : mmp_skid_buf
`default_nettype wire

// *** mmp_thread.sv ***
// Purpose: execution-unit side of the memory message link
// Assumes: user issues one request at a time
// Notes:   keeps the ordering the port does not guarantee
`timescale 1ns/10ps
`default_nettype none
module mmp_thread (
    input  wire logic                        clock_in,
    input  wire logic                        rst_in,
    mmp_if.thread_end                        link,
    input  wire logic                        req_valid_in,
    output logic                             req_ready_out,
    input  wire mmp_pkg::mmp_msg_s           req_in,
    output logic                             done_out,
    output var mmp_pkg::mmp_rsp_s            done_rsp_out
);
    typedef enum logic [1:0] {MMT_IDLE, MMT_SEND, MMT_WAIT} mmt_state_e;

    mmt_state_e        state_reg;
    mmp_pkg::mmp_msg_s msg_reg;
    logic              done_reg;
    mmp_pkg::mmp_rsp_s done_rsp_reg;

    // reads and committed writes hold the thread until the answer returns
    wire needs_wait = (msg_reg.sfid == mmp_pkg::MMP_SFID_READ) | msg_reg.commit;
    // stateless media block is never issued
    wire bad_media  = (req_in.op == mmp_pkg::MMP_OP_MEDIA_BLOCK) &
                      (req_in.bti == mmp_pkg::STATELESS_BTI);

    assign req_ready_out = (state_reg == MMT_IDLE);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg    <= MMT_IDLE;
            msg_reg      <= '0;
            done_reg     <= 1'b0;
            done_rsp_reg <= '0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                MMT_IDLE: begin
                    if (req_valid_in && !bad_media) begin
                        msg_reg   <= req_in;
                        // a write stays in the render cache path
                        if (req_in.sfid == mmp_pkg::MMP_SFID_WRITE)
                            msg_reg.cache_sel <= mmp_pkg::MMP_CACHE_RENDER;
                        state_reg <= MMT_SEND;
                    end
                end
                MMT_SEND: begin
                    if (link.msg_ready)
                        state_reg <= needs_wait ? MMT_WAIT : MMT_IDLE;
                end
                MMT_WAIT: begin
                    if (link.rsp_valid) begin
                        done_reg     <= 1'b1;
                        done_rsp_reg <= link.rsp;
                        state_reg    <= MMT_IDLE;
                    end
                end
                default: state_reg <= MMT_IDLE;
            endcase
        end
    end

    assign link.msg_valid = (state_reg == MMT_SEND);
    assign link.msg       = msg_reg;
    assign link.rsp_ready = (state_reg == MMT_WAIT);
    assign done_out       = done_reg;
    assign done_rsp_out   = done_rsp_reg;
endmodule : mmp_thread
`default_nettype wire

// *** mmp_port_asserts.sv ***
// Purpose: interface checks for the memory message link
// Assumes: single clock domain, synchronous active-high reset
// Notes:   helper flags remember what the last accepted message asked for
`timescale 1ns/10ps
`default_nettype none
module mmp_asserts (
    input wire logic              clock_in,
    input wire logic              rst_in,
    input wire logic              msg_valid,
    input wire logic              msg_ready,
    input wire mmp_pkg::mmp_msg_s msg,
    input wire logic              rsp_valid,
    input wire logic              rsp_ready,
    input wire mmp_pkg::mmp_rsp_s rsp
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic take;
    logic wants_rsp;
    logic pend_reg;
    logic was_wr_reg;
    logic dual_eq_reg;
    assign take      = msg_valid && msg_ready;
    assign wants_rsp = (msg.sfid == mmp_pkg::MMP_SFID_READ) || msg.commit;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pend_reg <= 1'b0;
        end else if (take && wants_rsp) begin
            pend_reg <= 1'b1;
        end else if (rsp_valid && rsp_ready) begin
            pend_reg <= 1'b0;
        end
    end
    always_ff @(posedge clock_in) begin
        if (take) begin
            was_wr_reg  <= (msg.sfid == mmp_pkg::MMP_SFID_WRITE);
            dual_eq_reg <= (msg.op == mmp_pkg::MMP_OP_DUAL_BLOCK) && (msg.offset0 == msg.offset1);
        end
    end
    property p_msg_hold; msg_valid && !msg_ready |=> msg_valid && $stable(msg); endproperty
    a_msg_hold: assert property (p_msg_hold) else $error("message changed while stalled");
    property p_rsp_hold; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp); endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("answer changed while stalled");
    property p_no_stateless_media;
        msg_valid |-> !(msg.op == mmp_pkg::MMP_OP_MEDIA_BLOCK && msg.bti == mmp_pkg::STATELESS_BTI);
    endproperty
    a_no_stateless_media: assert property (p_no_stateless_media) else $error("stateless media sent");
    property p_one_at_a_time; pend_reg |-> !msg_valid; endproperty
    a_one_at_a_time: assert property (p_one_at_a_time) else $error("message sent before answer");
    property p_answer_bound; take && wants_rsp |-> ##[2:10] rsp_valid; endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("answer missing");
    property p_silent_write;
        take && msg.sfid == mmp_pkg::MMP_SFID_WRITE && !msg.commit |=> !rsp_valid [*6];
    endproperty
    a_silent_write: assert property (p_silent_write) else $error("answer to uncommitted write");
    property p_commit_kind; rsp_valid |-> rsp.is_commit == was_wr_reg; endproperty
    a_commit_kind: assert property (p_commit_kind) else $error("commit flag wrong");
    property p_dual_one;
        rsp_valid && dual_eq_reg && rsp.status == mmp_pkg::MMP_ST_OK |-> rsp.rdata1 == rsp.rdata0;
    endproperty
    a_dual_one: assert property (p_dual_one) else $error("equal dual words differ");
    property p_no_rsp_idle; !pend_reg |-> !rsp_valid; endproperty
    a_no_rsp_idle: assert property (p_no_rsp_idle) else $error("answer without request");
endmodule : mmp_asserts
`default_nettype wire

// *** test_memory_message_port.sv ***
// Purpose: self-checking bench for thread end and port end joined by the link
// Assumes: 250 MHz clock, inputs driven on the falling edge
// Notes:   one request at a time; only the six-write plain burst fills the two-entry buffer from here
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH at %0t: value differs", $time); end end
module test_memory_message_port;
    logic              clock_in = 1'b0;
    logic              rst_in   = 1'b1;
    logic [31:0]       gen_base = 32'h0000_0300;
    logic [31:0]       gen_bound = 32'h0000_0380;
    logic              bt_wr = 1'b0;
    logic [3:0]        bt_idx = 4'h0;
    logic [31:0]       bt_base = 32'h0000_0000;
    logic              bt_is_buf = 1'b0;
    logic              busy;
    logic [1:0]        last_cache;
    logic              req_valid = 1'b0;
    logic              req_ready;
    mmp_pkg::mmp_msg_s req = '0;
    logic              done;
    mmp_pkg::mmp_rsp_s done_rsp;
    int                errors = 0;
    int                num_checks = 0;
    always #2 clock_in = ~clock_in;
    mmp_if i_mmp_if (.clock_in(clock_in));
    mmp_port i_mmp_port (.clock_in, .rst_in, .link(i_mmp_if), .gen_state_base_in(gen_base),
        .gen_state_bound_in(gen_bound), .bt_wr_in(bt_wr), .bt_idx_in(bt_idx), .bt_base_in(bt_base),
        .bt_size_in(32'h0000_0100), .bt_is_buffer_in(bt_is_buf), .busy_out(busy), .last_cache_out(last_cache));
    mmp_thread i_mmp_thread (.clock_in, .rst_in, .link(i_mmp_if), .req_valid_in(req_valid),
        .req_ready_out(req_ready), .req_in(req), .done_out(done), .done_rsp_out(done_rsp));
    mmp_asserts i_mmp_asserts (.clock_in, .rst_in, .msg_valid(i_mmp_if.msg_valid), .msg_ready(i_mmp_if.msg_ready),
        .msg(i_mmp_if.msg), .rsp_valid(i_mmp_if.rsp_valid), .rsp_ready(i_mmp_if.rsp_ready), .rsp(i_mmp_if.rsp));
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    function automatic mmp_pkg::mmp_msg_s mk(input mmp_pkg::mmp_sfid_e s, input mmp_pkg::mmp_op_e op,
        input mmp_pkg::mmp_cache_e c, input logic [7:0] bti, input logic [31:0] o0, input logic [31:0] o1,
        input logic [31:0] d);
        mmp_pkg::mmp_msg_s m;
        m = '0;
        m.sfid = s; m.op = op; m.cache_sel = c; m.bti = bti; m.offset0 = o0; m.offset1 = o1; m.wdata = d;
        m.commit = (s == mmp_pkg::MMP_SFID_WRITE);
        m.fmt_channels = mmp_pkg::CH_ALL;
        return m;
    endfunction : mk
    task automatic bt_load(input logic [3:0] idx, input logic [31:0] base, input logic is_buf);
        @(negedge clock_in);
        bt_wr = 1'b1; bt_idx = idx; bt_base = base; bt_is_buf = is_buf;
        @(negedge clock_in);
        bt_wr = 1'b0;
    endtask : bt_load
    // the extra falling edge up front keeps back-to-back calls from touching req_valid twice at once
    task automatic send(input mmp_pkg::mmp_msg_s m, input bit wait_done);
        int n;
        @(negedge clock_in);
        while (req_ready !== 1'b1) @(negedge clock_in);
        req = m;
        req_valid = 1'b1;
        @(negedge clock_in);
        req_valid = 1'b0;
        n = 0;
        while (wait_done && done !== 1'b1 && n < 40) begin
            @(negedge clock_in);
            n++;
            if (n == 2) `CHK(busy, 1'b1)
        end
        if (wait_done) `CHK(done, 1'b1)
    endtask : send
    task automatic wr(input mmp_pkg::mmp_msg_s m);
        send(m, 1'b1);
        `CHK(done_rsp.is_commit, 1'b1)
        `CHK(done_rsp.status, mmp_pkg::MMP_ST_OK)
        `CHK(last_cache, 2'b10)
    endtask : wr
    task automatic rd(input mmp_pkg::mmp_msg_s m, input logic [31:0] e0, input mmp_pkg::mmp_status_e st);
        send(m, 1'b1);
        `CHK(busy, 1'b0)
        `CHK(done_rsp.is_commit, 1'b0)
        `CHK(done_rsp.status, st)
        if (st == mmp_pkg::MMP_ST_OK && m.op != mmp_pkg::MMP_OP_MEDIA_BLOCK) begin
            `CHK(done_rsp.rdata0, e0)
            `CHK(last_cache, {1'b1, m.cache_sel})
        end
    endtask : rd
    initial begin
        repeat (20000) @(posedge clock_in);
        errors++;
        wrap_up();
    end
    initial begin
        mmp_pkg::mmp_op_e   ops [3];
        mmp_pkg::mmp_msg_s  m;
        ops = '{mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_OP_SCATTER, mmp_pkg::MMP_OP_VERTEX_WR};
        repeat (5) @(posedge clock_in);
        @(negedge clock_in);
        rst_in = 1'b0;
        bt_load(4'h1, 32'h0000_0040, 1'b1);
        bt_load(4'h2, 32'h0000_0200, 1'b0);
        bt_load(4'h3, 32'h0000_0310, 1'b1);
        for (int k = 0; k < 3; k++) begin
            // a write asking for the data cache still lands in the render cache
            wr(mk(mmp_pkg::MMP_SFID_WRITE, ops[k], mmp_pkg::MMP_CACHE_DATA, 8'h01, 4 * k, 0, 32'h1234_0000 + k));
            rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h01, 4 * k, 0, 0),
                32'h1234_0000 + k, mmp_pkg::MMP_ST_OK);
            rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_SCATTER, mmp_pkg::MMP_CACHE_DATA, 8'h01, 4 * k, 0, 0),
                32'h1234_0000 + k, mmp_pkg::MMP_ST_OK);
        end
        m = mk(mmp_pkg::MMP_SFID_WRITE, mmp_pkg::MMP_OP_VERTEX_WR, mmp_pkg::MMP_CACHE_RENDER, 8'h01, 0, 0, 32'h5566_7788);
        m.fmt_channels = 4'h3;
        wr(m);
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h01, 0, 0, 0),
            32'h1234_7788, mmp_pkg::MMP_ST_OK);
        wr(mk(mmp_pkg::MMP_SFID_WRITE, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'hff, 0, 32'h10, 32'hcafe_0001));
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h03, 0, 0, 0),
            32'hcafe_0001, mmp_pkg::MMP_ST_OK);
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_DATA, 8'hff, 0, 32'h10, 0),
            32'hcafe_0001, mmp_pkg::MMP_ST_OK);
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'hff, 0, 32'h90, 0),
            0, mmp_pkg::MMP_ST_BOUND_ERR);
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_DUAL_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h01, 4, 4, 0),
            32'h1234_0001, mmp_pkg::MMP_ST_OK);
        `CHK(done_rsp.rdata1, 32'h1234_0001)
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_DUAL_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h01, 4, 8, 0),
            32'h1234_0001, mmp_pkg::MMP_ST_OK);
        `CHK(done_rsp.rdata1, 32'h1234_0002)
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_MEDIA_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h02, 0, 0, 0),
            0, mmp_pkg::MMP_ST_OK);
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_MEDIA_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h01, 0, 0, 0),
            0, mmp_pkg::MMP_ST_ILLEGAL);
        rd(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h02, 0, 0, 0),
            0, mmp_pkg::MMP_ST_ILLEGAL);
        send(mk(mmp_pkg::MMP_SFID_READ, mmp_pkg::MMP_OP_MEDIA_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'hff, 0, 0, 0), 1'b0);
        repeat (8) begin @(negedge clock_in); `CHK(i_mmp_if.msg_valid, 1'b0) end
        `CHK(req_ready, 1'b1)
        m = mk(mmp_pkg::MMP_SFID_WRITE, mmp_pkg::MMP_OP_BLOCK, mmp_pkg::MMP_CACHE_RENDER, 8'h01, 12, 0, 32'h0000_00aa);
        m.commit = 1'b0;
        // a burst of six plain writes gets no answer and leaves the port idle
        for (int j = 0; j < 6; j++) begin
            m.offset0 = 32'(12 + 4 * j);
            send(m, 1'b0);
        end
        repeat (16) begin @(negedge clock_in); `CHK(done, 1'b0) end
        `CHK(busy, 1'b0)
        wrap_up();
    end
endmodule : test_memory_message_port
`default_nettype wire
